// ---- hdl/ucr_top.sv ----
// ucr_top: uart that answers with four bytes each character received while no answer is being sent.
// assumes an AHB-Lite master on mclk_in and a remote device on the lines.
`timescale 1ns/1ps
`default_nettype none
module ucr_top
  import ucr_pkg::*;
#(
  parameter int unsigned BIT_DIV = BIT_CYCLES  // clocks per bit; a bench may shorten it
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // serial lines
  input  wire logic        serial_rx_line_in,
  output logic             serial_tx_line_out,
  // events
  output logic             rx_done_event_out,
  output logic             tx_done_event_out,
  output logic             rx_error_event_out,
  output logic             irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  // bit timing: mclk_in is the 125 MHz CLK_HZ clock, not the 24 MHz peripheral clock; the
  // default divider keeps 9600 bps within 0.01 percent
  localparam logic [15:0] BIT_CNT  = 16'(BIT_DIV - 1);
  localparam logic [15:0] HALF_CNT = 16'(BIT_DIV / 2 - 1);
  ////////////////////////////////////////////////////////////////////////////
  // receive line synchroniser, two flops before use
  logic rx_meta_q;
  logic rx_sync_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= serial_rx_line_in;
      rx_sync_q <= rx_meta_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers shared with the bus slave
  logic [EV_BITS-1:0] status_q;
  logic [EV_BITS-1:0] mask_q;
  logic [1:0]         ctrl_q;
  logic [7:0]         rx_data_q;
  logic               rx_unread_q;
  logic               enable;
  assign enable = ctrl_q[CTRL_ENABLE];
  ////////////////////////////////////////////////////////////////////////////
  // receiver
  ucr_frame_t  rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_shift_q;
  logic        rx_par_q;
  logic        rx_end;       // one-cycle pulse at stop sample
  logic        rx_par_bad_q;
  logic        stop_ok;
  assign stop_ok = rx_sync_q;
  assign rx_end  = (rx_st_q == FR_STOP) && (rx_cnt_q == 16'h0000);

  // line low while idle starts a frame; high is idle
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_st_q      <= FR_IDLE;
      rx_cnt_q     <= 16'h0000;
      rx_bit_q     <= 3'h0;
      rx_shift_q   <= 8'h00;
      rx_par_q     <= 1'b0;
      rx_par_bad_q <= 1'b0;
    end else begin
      if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end
      case (rx_st_q)
        FR_IDLE: begin
          if (enable && !rx_sync_q) begin
            rx_st_q  <= FR_START;
            rx_cnt_q <= HALF_CNT;
          end
        end
        FR_START: begin
          if (rx_cnt_q == 16'h0000) begin
            // a glitch shorter than half a bit is dropped
            rx_st_q  <= rx_sync_q ? FR_IDLE : FR_DATA;
            rx_cnt_q <= BIT_CNT;
            rx_bit_q <= 3'h0;
            rx_par_q <= 1'b0;
          end
        end
        FR_DATA: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
            rx_par_q   <= rx_par_q ^ rx_sync_q;
            rx_cnt_q   <= BIT_CNT;
            rx_bit_q   <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'(DATA_BITS - 1)) begin
              rx_st_q <= FR_PARITY;
            end
          end
        end
        FR_PARITY: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_par_bad_q <= rx_par_q ^ rx_sync_q;
            rx_st_q      <= FR_STOP;
            rx_cnt_q     <= BIT_CNT;
          end
        end
        FR_STOP: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_st_q <= FR_IDLE;
          end
        end
        default: begin
          rx_st_q <= FR_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // classify the finished frame; framing beats parity beats overrun
  logic      rx_good;
  logic      rx_fe;
  logic      rx_pe;
  logic      rx_oe;
  ucr_resp_t rx_kind;
  assign rx_fe   = rx_end && !stop_ok;
  assign rx_pe   = rx_end && stop_ok && rx_par_bad_q;
  assign rx_oe   = rx_end && stop_ok && !rx_par_bad_q && rx_unread_q;
  assign rx_good = rx_end && stop_ok && !rx_par_bad_q && !rx_unread_q;

  always_comb begin
    if (!stop_ok) begin
      rx_kind = RSP_FE;
    end else if (rx_par_bad_q) begin
      rx_kind = RSP_PE;
    end else if (rx_unread_q) begin
      rx_kind = RSP_OE;
    end else if (rx_shift_q == CH_UP_T) begin
      rx_kind = RSP_OK_UP;
    end else if (rx_shift_q == CH_LO_T) begin
      rx_kind = RSP_OK_LO;
    end else begin
      rx_kind = RSP_UC;
    end
  end

  // received byte holding register; a bus read of it consumes it
  logic rd_rxdata;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_data_q   <= 8'h00;
      rx_unread_q <= 1'b0;
    end else if (rx_good) begin
      rx_data_q   <= rx_shift_q;
      rx_unread_q <= 1'b1;
    end else if (rd_rxdata) begin
      rx_unread_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // response sequencer and transmitter
  ucr_frame_t  tx_st_q;
  ucr_resp_t   tx_kind_q;
  logic [1:0]  tx_idx_q;
  logic [15:0] tx_cnt_q;
  logic [2:0]  tx_bit_q;
  logic [7:0]  tx_shift_q;
  logic        tx_par_q;
  logic        tx_busy_q;
  logic        tx_line_q;
  logic        tx_end;
  logic [7:0]  tx_byte;
  assign tx_end = tx_busy_q && (tx_st_q == FR_STOP) && (tx_cnt_q == 16'h0000)
                  && (tx_idx_q == 2'(RESP_LEN - 1));

  // first two characters by kind, then carriage return and line feed
  always_comb begin
    tx_byte = CH_CR;
    case (tx_idx_q)
      2'h0: begin
        case (tx_kind_q)
          RSP_OK_UP: tx_byte = CH_UP_O;
          RSP_OK_LO: tx_byte = CH_LO_O;
          RSP_UC:    tx_byte = CH_UP_U;
          RSP_PE:    tx_byte = CH_UP_P;
          RSP_FE:    tx_byte = CH_UP_F;
          RSP_OE:    tx_byte = CH_UP_O;
          default:   tx_byte = CH_UP_U;
        endcase
      end
      2'h1: begin
        case (tx_kind_q)
          RSP_OK_UP: tx_byte = CH_UP_K;
          RSP_OK_LO: tx_byte = CH_LO_K;
          RSP_UC:    tx_byte = CH_UP_C;
          default:   tx_byte = CH_UP_E;
        endcase
      end
      2'h2: tx_byte = CH_CR;
      default: tx_byte = CH_LF;
    endcase
  end

  // a frame arriving during an answer is dropped from the answer path:
  // the remote side is expected to wait for the line feed
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_st_q    <= FR_IDLE;
      tx_kind_q  <= RSP_UC;
      tx_idx_q   <= 2'h0;
      tx_cnt_q   <= 16'h0000;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_par_q   <= 1'b0;
      tx_busy_q  <= 1'b0;
      tx_line_q  <= 1'b1;
    end else begin
      if (tx_cnt_q != 16'h0000) begin
        tx_cnt_q <= tx_cnt_q - 16'h0001;
      end
      case (tx_st_q)
        FR_IDLE: begin
          tx_line_q <= 1'b1;
          if (!tx_busy_q && rx_end) begin
            tx_kind_q <= rx_kind;
            tx_idx_q  <= 2'h0;
            tx_busy_q <= 1'b1;
          end else if (tx_busy_q) begin
            tx_st_q    <= FR_START;
            tx_shift_q <= tx_byte;
            tx_par_q   <= ^tx_byte;
            tx_line_q  <= 1'b0;
            tx_cnt_q   <= BIT_CNT;
          end
        end
        FR_START: begin
          if (tx_cnt_q == 16'h0000) begin
            tx_st_q    <= FR_DATA;
            tx_line_q  <= tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q   <= 3'h0;
            tx_cnt_q   <= BIT_CNT;
          end
        end
        FR_DATA: begin
          if (tx_cnt_q == 16'h0000) begin
            tx_cnt_q <= BIT_CNT;
            if (tx_bit_q == 3'(DATA_BITS - 1)) begin
              tx_st_q   <= FR_PARITY;
              tx_line_q <= tx_par_q;
            end else begin
              tx_line_q  <= tx_shift_q[0];
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              tx_bit_q   <= tx_bit_q + 3'h1;
            end
          end
        end
        FR_PARITY: begin
          if (tx_cnt_q == 16'h0000) begin
            tx_st_q   <= FR_STOP;
            tx_line_q <= 1'b1;
            tx_cnt_q  <= BIT_CNT;
          end
        end
        FR_STOP: begin
          if (tx_cnt_q == 16'h0000) begin
            tx_st_q  <= FR_IDLE;
            tx_idx_q <= tx_idx_q + 2'h1;
            if (tx_idx_q == 2'(RESP_LEN - 1)) begin
              tx_busy_q <= 1'b0;
            end
          end
        end
        default: begin
          tx_st_q <= FR_IDLE;
        end
      endcase
    end
  end
  assign serial_tx_line_out = tx_line_q;
  ////////////////////////////////////////////////////////////////////////////
  // event pulses
  logic [EV_BITS-1:0] ev_set;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_done_event_out  <= 1'b0;
      tx_done_event_out  <= 1'b0;
      rx_error_event_out <= 1'b0;
    end else begin
      rx_done_event_out  <= rx_good;
      tx_done_event_out  <= tx_end;
      rx_error_event_out <= rx_fe || rx_pe || rx_oe;
    end
  end
  assign ev_set = {rx_oe, rx_fe, rx_pe, (rx_fe || rx_pe || rx_oe), tx_end, rx_good};
  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  logic       ph_wr_q;
  logic       ph_rd_q;
  logic [7:0] ph_addr_q;
  logic       take;
  logic       wr_status;
  assign take = hsel_in && htrans_in[1] && hready_in;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ph_wr_q   <= 1'b0;
      ph_rd_q   <= 1'b0;
      ph_addr_q <= 8'h00;
    end else begin
      ph_wr_q   <= take && hwrite_in;
      ph_rd_q   <= take && !hwrite_in;
      ph_addr_q <= haddr_in;
    end
  end
  assign wr_status = ph_wr_q && (ph_addr_q == REG_STATUS);

  // reading the data register consumes the byte at its address phase
  assign rd_rxdata = take && !hwrite_in && (haddr_in == REG_RXDATA);

  // status: set wins over write-one-to-clear
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(wr_status ? hwdata_in[EV_BITS-1:0] : '0)) | ev_set;
    end
  end

  // mask and control writes
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_q <= MASK_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (ph_wr_q) begin
      if (ph_addr_q == REG_MASK) begin
        mask_q <= hwdata_in[EV_BITS-1:0];
      end
      if (ph_addr_q == REG_CTRL) begin
        ctrl_q <= hwdata_in[1:0];
      end
    end
  end

  // read data registered at the address phase
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata_out <= 32'h00000000;
    end else if (take && !hwrite_in) begin
      case (haddr_in)
        REG_STATUS: hrdata_out <= {26'h0, status_q};
        REG_MASK:   hrdata_out <= {26'h0, mask_q};
        REG_RXDATA: hrdata_out <= {23'h0, rx_unread_q, rx_data_q};
        REG_CTRL:   hrdata_out <= {28'h0, tx_busy_q, rx_unread_q, ctrl_q};
        default:    hrdata_out <= 32'h00000000;
      endcase
    end
  end

  // interrupt: any status bit enabled in the mask, with no order among them
  assign irq_out = |(status_q & mask_q);
endmodule
`default_nettype wire

// ---- hdl/ucr_pkg.sv ----
// ucr_pkg: constants for the character responder uart.
// assumes a single 125 MHz clock and an AHB-Lite register slave.
package ucr_pkg;
  // clocking and bit timing
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned PERIPH_HZ     = 24000000;
  localparam int unsigned BAUD_BPS      = 9600;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_BPS;
  localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned RESP_LEN      = 4;
  // register byte offsets
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_MASK       = 8'h04;
  localparam logic [7:0] REG_RXDATA     = 8'h08;
  localparam logic [7:0] REG_CTRL       = 8'h0C;
  // status and mask bit positions
  localparam int unsigned EV_RX_DONE    = 0;
  localparam int unsigned EV_TX_DONE    = 1;
  localparam int unsigned EV_RX_ERR     = 2;
  localparam int unsigned EV_PAR_ERR    = 3;
  localparam int unsigned EV_FRM_ERR    = 4;
  localparam int unsigned EV_OVR_ERR    = 5;
  localparam int unsigned EV_BITS       = 6;
  localparam logic [EV_BITS-1:0] MASK_RESET = 6'h00;
  // control bits
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam logic [1:0] CTRL_RESET     = 2'h1;
  // characters
  localparam logic [7:0] CH_UP_T  = 8'h54;
  localparam logic [7:0] CH_LO_T  = 8'h74;
  localparam logic [7:0] CH_UP_O  = 8'h4F;
  localparam logic [7:0] CH_UP_K  = 8'h4B;
  localparam logic [7:0] CH_LO_O  = 8'h6F;
  localparam logic [7:0] CH_LO_K  = 8'h6B;
  localparam logic [7:0] CH_UP_U  = 8'h55;
  localparam logic [7:0] CH_UP_C  = 8'h43;
  localparam logic [7:0] CH_UP_P  = 8'h50;
  localparam logic [7:0] CH_UP_E  = 8'h45;
  localparam logic [7:0] CH_UP_F  = 8'h46;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  // response kinds
  typedef enum logic [2:0] {
    RSP_OK_UP = 3'h0,
    RSP_OK_LO = 3'h1,
    RSP_UC    = 3'h2,
    RSP_PE    = 3'h3,
    RSP_FE    = 3'h4,
    RSP_OE    = 3'h5
  } ucr_resp_t;
  // frame state machines
  typedef enum logic [4:0] {
    FR_IDLE   = 5'b00001,
    FR_START  = 5'b00010,
    FR_DATA   = 5'b00100,
    FR_PARITY = 5'b01000,
    FR_STOP   = 5'b10000
  } ucr_frame_t;
endpackage

// ---- tb/ucr_monitor.sv ----
// ucr_monitor: timing checks on the responder's serial and event ports.
// assumes it is bound into ucr_top and that the bus clock drives the bit timing.
`timescale 1ns/1ps
`default_nettype none
module ucr_monitor
  import ucr_pkg::*;
#(
  parameter int unsigned BIT_DIV = BIT_CYCLES  // clocks per bit, as in the design
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // serial lines
  input wire logic serial_rx_line_in,
  input wire logic serial_tx_line_out,
  // events
  input wire logic rx_done_event_out,
  input wire logic tx_done_event_out,
  input wire logic rx_error_event_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  //////////////////////////////////////////////////
  // length of the current low run on tx; a 32-bit count outlasts any legal run
  int unsigned low_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_q <= 0;
    end else if (serial_tx_line_out) begin
      low_q <= 0;
    end else begin
      low_q <= low_q + 1;
    end
  end
  //////////////////////////////////////////////////
  // an answer starts with a start bit soon after the event
  sequence s_answer_start;
    ##[1:4] !serial_tx_line_out;
  endsequence
  // line stays idle after the last stop bit
  sequence s_line_idle;
    serial_tx_line_out [*8];
  endsequence
  AST_RX_ANSWER: assert property (rx_done_event_out |-> s_answer_start)
    else $error("no start bit after a received byte");
  AST_ERR_ANSWER: assert property (rx_error_event_out |-> s_answer_start)
    else $error("no start bit after a receive error");
  AST_IDLE_AFTER: assert property (tx_done_event_out |-> s_line_idle)
    else $error("tx line not idle after the answer");
  AST_BIT_TIME: assert property ($rose(serial_tx_line_out) |-> (low_q % BIT_DIV) == 0)
    else $error("tx low run is not a whole number of bits");
  AST_STOP_HIGH: assert property (rx_done_event_out |-> $past(serial_rx_line_in, 4))
    else $error("good byte reported with a low stop bit");
  AST_RX_PULSE: assert property (rx_done_event_out |=> !rx_done_event_out)
    else $error("receive event longer than one cycle");
  AST_TX_PULSE: assert property (tx_done_event_out |=> !tx_done_event_out)
    else $error("transmit event longer than one cycle");
  AST_ERR_PULSE: assert property (rx_error_event_out |=> !rx_error_event_out)
    else $error("error event longer than one cycle");
endmodule
bind ucr_top ucr_monitor #(.BIT_DIV(BIT_DIV)) i_ucr_monitor (
  .mclk_in            (mclk_in),
  .reset_n_in         (reset_n_in),
  .serial_rx_line_in  (serial_rx_line_in),
  .serial_tx_line_out (serial_tx_line_out),
  .rx_done_event_out  (rx_done_event_out),
  .tx_done_event_out  (tx_done_event_out),
  .rx_error_event_out (rx_error_event_out)
);
`default_nettype wire

// ---- tb/ucr_remote.sv ----
// ucr_remote: the remote serial device, sending frames and decoding answers.
// assumes the bus clock paces its bits; its line idles high.
`timescale 1ns/1ps
`default_nettype none
module ucr_remote
  import ucr_pkg::*;
#(
  parameter int unsigned BIT_DIV = BIT_CYCLES  // clocks per bit, as in the design
) (
  // timing clock
  input wire logic mclk_in,
  // lines seen from the remote side
  output var logic to_dev_out,
  input wire logic from_dev_in
);
  logic [7:0] got_q[$];
  int         bad_frames = 0;
  initial to_dev_out = 1'b1;
  //////////////////////////////////////////////////
  // one frame: start, data lsb first, parity, stop; flags force errors
  task automatic send(input logic [7:0] b, input bit bad_par, input bit bad_stop);
    logic [10:0] f;
    f = {~bad_stop, (^b) ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      to_dev_out <= f[i];
      repeat (BIT_DIV) @(posedge mclk_in);
    end
    to_dev_out <= 1'b1;
  endtask
  //////////////////////////////////////////////////
  // decode answers at mid bit; any bad start, parity or stop is counted
  always begin : rcv
    logic [9:0] r;
    @(negedge from_dev_in);
    repeat (BIT_DIV / 2) @(posedge mclk_in);
    if (from_dev_in !== 1'b0) bad_frames++;
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_DIV) @(posedge mclk_in);
      r[i] = from_dev_in;
    end
    if (r[8] !== ^r[7:0] || r[9] !== 1'b1) bad_frames++;
    got_q.push_back(r[7:0]);
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// tb: drives the responder over its bus and through the remote model.
// assumes one 125 MHz clock; bits are shortened, each exchange takes under 2k cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ucr_pkg::*;
  logic        mclk_in, reset_n_in, hsel_in, hwrite_in, hready, hresp;
  logic        rx_line, tx_line, rxd_ev, txd_ev, err_ev, irq;
  logic [7:0]  haddr_in;
  logic [1:0]  htrans_in;
  logic [31:0] hwdata_in, hrdata;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          rx_evs = 0;
  int          err_evs = 0;
  localparam int unsigned TB_BIT = 32;  // short bit keeps the run small; timing is relative
  //////////////////////////////////////////////////
  ucr_top #(.BIT_DIV(TB_BIT)) i_ucr_top (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .serial_rx_line_in(rx_line), .serial_tx_line_out(tx_line),
    .rx_done_event_out(rxd_ev), .tx_done_event_out(txd_ev), .rx_error_event_out(err_ev),
    .irq_out(irq));
  ucr_remote #(.BIT_DIV(TB_BIT)) i_ucr_remote (.mclk_in(mclk_in), .to_dev_out(rx_line),
    .from_dev_in(tx_line));
  //////////////////////////////////////////////////
  // clock, event pulse counts, and a ceiling sized for seven short-bit exchanges
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (rxd_ev === 1'b1) rx_evs <= rx_evs + 1;
    if (err_ev === 1'b1) err_evs <= err_evs + 1;
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  //////////////////////////////////////////////////
  // one single transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_in   <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in  <= a;
    hwrite_in <= wr;
    do @(posedge mclk_in); while (hready !== 1'b1);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // send a frame, collect four answer bytes, wait for the end event
  task automatic exchange(input logic [7:0] b, input bit bp, input bit bs,
                          input logic [15:0] ans);
    i_ucr_remote.got_q.delete();
    i_ucr_remote.send(b, bp, bs);
    while (i_ucr_remote.got_q.size() < 4) @(posedge mclk_in);
    check("answer", {ans, CH_CR, CH_LF}, {i_ucr_remote.got_q[0], i_ucr_remote.got_q[1],
          i_ucr_remote.got_q[2], i_ucr_remote.got_q[3]});
    while (txd_ev !== 1'b1) @(posedge mclk_in);
    @(posedge mclk_in);
  endtask
  //////////////////////////////////////////////////
  // reset values and an unmapped address
  task automatic t_regs;
    logic [31:0] rd;
    bus(1'b0, REG_MASK, 32'h0, rd);
    check("mask", 32'h0, rd);
    bus(1'b0, REG_CTRL, 32'h0, rd);
    check("ctrl", 32'h1, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask
  // each character kind, with the receive interrupt unmasked
  task automatic t_chars;
    logic [31:0] rd;
    logic [7:0]  ch[3];
    logic [15:0] an[3];
    ch = '{CH_UP_T, CH_LO_T, 8'h41};
    an = '{{CH_UP_O, CH_UP_K}, {CH_LO_O, CH_LO_K}, {CH_UP_U, CH_UP_C}};
    bus(1'b1, REG_MASK, 32'h01, rd);
    for (int i = 0; i < 3; i++) begin
      exchange(ch[i], 1'b0, 1'b0, an[i]);
      bus(1'b0, REG_STATUS, 32'h0, rd);
      check("status", 32'h03, rd);
      check("irq", 32'h1, {31'h0, irq});
      bus(1'b1, REG_STATUS, 32'h01, rd);
      // the clear lands at the bus task's last edge; look once it has settled
      @(posedge mclk_in);
      check("masked irq", 32'h0, {31'h0, irq}); // tx bit set but masked
      bus(1'b0, REG_RXDATA, 32'h0, rd);
      check("rxdata", {23'h0, 1'b1, ch[i]}, rd);
      bus(1'b1, REG_STATUS, 32'h3F, rd);
    end
    bus(1'b1, REG_MASK, 32'h00, rd);
  endtask
  // parity, framing, then an unread byte overrun
  task automatic t_errors;
    logic [31:0] rd;
    exchange(8'h54, 1'b1, 1'b0, {CH_UP_P, CH_UP_E});
    bus(1'b0, REG_STATUS, 32'h0, rd);
    check("parity status", 32'h0E, rd);
    bus(1'b1, REG_STATUS, 32'h3F, rd);
    bus(1'b0, REG_RXDATA, 32'h0, rd);
    exchange(8'h74, 1'b0, 1'b1, {CH_UP_F, CH_UP_E});
    bus(1'b0, REG_STATUS, 32'h0, rd);
    check("framing status", 32'h16, rd);
    bus(1'b1, REG_STATUS, 32'h3F, rd);
    bus(1'b0, REG_RXDATA, 32'h0, rd);
    exchange(8'h41, 1'b0, 1'b0, {CH_UP_U, CH_UP_C});
    exchange(8'h42, 1'b0, 1'b0, {CH_UP_O, CH_UP_E});
    bus(1'b0, REG_STATUS, 32'h0, rd);
    check("overrun status", 32'h26, rd & 32'h26);
    check("frames", 32'h0, i_ucr_remote.bad_frames);
    check("rx events", 32'h4, rx_evs);
    check("error events", 32'h3, err_evs);
  endtask
  //////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_n_in = 1'b0;
    hsel_in    = 1'b0;
    htrans_in  = 2'h0;
    haddr_in   = 8'h00;
    hwrite_in  = 1'b0;
    hwdata_in  = 32'h0;
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    t_regs();
    t_chars();
    t_errors();
    wrap_up();
  end
endmodule
`default_nettype wire
